// [verilog/dpr_pkg.sv]
// Constants, types and coding functions for the dual-port memory tile.
// Assumes one clock domain and an APB master that drives the register bus.
// Functional notes
// - 36Kb array shared by two independent ports.
// - Runs as one 36Kb or two 18Kb memories.
// - All port inputs captured on the port clock.
// - Address held between operations unless latching disabled.
// - Optional output register adds one cycle latency.
// - Write-cycle output: old data, new data, unchanged.
// - Extra input gates array power dynamically.
// - Port shapes 32Kx1 through 512x72 supported.
// - Ports may use different shapes freely outside split mode.
// - Each 18Kb half supports 16Kx1 to 512x36.
// - Wide ports only in read_write_split_mode.
// - Split mode fixes one side at widest width.
// - Eight Hamming bits, correct single, detect double.
// - Coder usable for external 64-72 bit memories.
// - FIFO of 36Kb or 18Kb, on the one shared pclk.
// - FIFO advances pointers, drives four flags.
// - Threshold flag levels set by user.
// - FIFO sides may differ in data width.
// - Cascade path chains adjacent tiles.
package dpr_pkg;

	// ==========================================================
	// Geometry.
	localparam int WORD_W = 72;
	localparam int DATA_W = 64;
	localparam int MEM_WORDS = 512;
	localparam logic [15:0] FULL_BITS = 16'h9000;
	localparam logic [15:0] HALF_BITS = 16'h4800;
	localparam logic [15:0] WORD_BITS = 16'h0048;

	// ==========================================================
	// Register offsets.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_AFULL = 12'h004;
	localparam logic [11:0] OFS_AEMPTY = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;
	localparam logic [11:0] OFS_ECCCNT = 12'h010;

	// ==========================================================
	// Control register fields.
	localparam int CTRL_FIFO = 0;
	localparam int CTRL_SPLIT = 1;
	localparam int CTRL_RWS = 2;
	localparam int CTRL_OREG_A = 3;
	localparam int CTRL_OREG_B = 4;
	localparam int CTRL_ADIS = 5;
	localparam int CTRL_ECC = 6;
	localparam int CTRL_CASC = 7;
	localparam int CTRL_WM_A = 8;
	localparam int CTRL_WM_B = 10;
	localparam int CTRL_WID_A = 12;
	localparam int CTRL_WID_B = 16;
	localparam int CTRL_FLUSH = 24;

	// ==========================================================
	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [15:0] RST_AFULL = 16'h8000;
	localparam logic [15:0] RST_AEMPTY = 16'h0100;

	// ==========================================================
	// Port widths and write-cycle output modes.
	typedef enum logic [2:0] {
		DPR_W1 = 3'h0, DPR_W2 = 3'h1, DPR_W4 = 3'h2, DPR_W9 = 3'h3,
		DPR_W18 = 3'h4, DPR_W36 = 3'h5, DPR_W72 = 3'h6
	} dpr_width_e;

	typedef enum logic [1:0] {
		DPR_READ_FIRST = 2'h0, DPR_WRITE_FIRST = 2'h1, DPR_NO_CHANGE = 2'h2
	} dpr_wmode_e;

	// ==========================================================
	// Whole register state of the tile, memory array excluded.
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] afull_th;
		logic [15:0] aempty_th;
		logic [31:0] prdata;
		logic [1:0] en;
		logic [1:0] we;
		logic [1:0][15:0] addr;
		logic [1:0][71:0] din;
		logic [1:0][71:0] dout1;
		logic [1:0] sb1;
		logic [1:0] db1;
		logic [1:0][71:0] dout2;
		logic [1:0] sb2;
		logic [1:0] db2;
		logic rv1;
		logic rv2;
		logic [15:0] wptr;
		logic [15:0] rptr;
		logic [16:0] cnt;
		logic full;
		logic empty;
		logic afull;
		logic aempty;
		logic [15:0] sgl_cnt;
		logic [15:0] dbl_cnt;
		logic [71:0] enc;
		logic [65:0] dec;
	} dpr_state_s;

	// Number of data bits carried by a width code.
	function automatic logic [6:0] width_bits(input logic [2:0] c);
		case (c)
			DPR_W1: width_bits = 7'h01;
			DPR_W2: width_bits = 7'h02;
			DPR_W4: width_bits = 7'h04;
			DPR_W9: width_bits = 7'h09;
			DPR_W18: width_bits = 7'h12;
			DPR_W36: width_bits = 7'h24;
			default: width_bits = 7'h48;
		endcase
	endfunction

	// Mask of the low w bits; w of 72 gives all ones.
	function automatic logic [71:0] width_mask(input logic [6:0] w);
		width_mask = (72'h1 << w) - 72'h1;
	endfunction

	// Hamming SEC-DED encoder: returns {overall, check[6:0], data}.
	function automatic logic [71:0] ecc_encode(input logic [63:0] d);
		logic [71:1] c;
		logic [6:0] p;
		int j;
		c = '0;
		p = '0;
		j = 0;
		for (int pos = 1; pos < 72; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				c[pos] = d[j];
				j++;
			end
		end
		for (int i = 0; i < 7; i++) begin
			for (int pos = 1; pos < 72; pos++) begin
				if (((pos >> i) & 1) == 1) begin
					p[i] = p[i] ^ c[pos];
				end
			end
		end
		ecc_encode = {(^d) ^ (^p), p, d};
	endfunction

	// Hamming SEC-DED decoder: returns {double, single, corrected data}.
	function automatic logic [65:0] ecc_decode(input logic [71:0] w);
		logic [71:1] c;
		logic [6:0] s;
		logic [63:0] d;
		logic ovr;
		int j;
		c = '0;
		s = w[70:64];
		d = w[63:0];
		ovr = ^w;
		j = 0;
		for (int pos = 1; pos < 72; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				c[pos] = w[j];
				j++;
			end
		end
		for (int i = 0; i < 7; i++) begin
			for (int pos = 1; pos < 72; pos++) begin
				if (((pos >> i) & 1) == 1) begin
					s[i] = s[i] ^ c[pos];
				end
			end
		end
		j = 0;
		for (int pos = 1; pos < 72; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (ovr && (pos == int'(s))) begin
					d[j] = ~d[j];
				end
				j++;
			end
		end
		ecc_decode = {(s != 7'h00) && !ovr, ovr, d};
	endfunction

endpackage

// [verilog/dpr_tile.sv]
// Dual-port memory tile with RAM, FIFO and SEC-DED modes.
// Assumes fabric logic on pclk drives both ports and an APB master the registers.
`timescale 1ns/1ps
module dpr_tile (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A, also the FIFO write side.
	input wire logic a_ce,
	input wire logic a_we,
	input wire logic [15:0] a_addr,
	input wire logic [71:0] a_din,
	output logic [71:0] a_dout,
	output logic a_sbit_err,
	output logic a_dbit_err,
	// Port B, also the FIFO read side.
	input wire logic b_ce,
	input wire logic b_we,
	input wire logic [15:0] b_addr,
	input wire logic [71:0] b_din,
	output logic [71:0] b_dout,
	output logic b_sbit_err,
	output logic b_dbit_err,
	// FIFO flags.
	output logic fifo_full,
	output logic fifo_empty,
	output logic fifo_afull,
	output logic fifo_aempty,
	// Array power gating.
	input wire logic pwr_gate,
	// Stand-alone coder for external memories.
	input wire logic [63:0] ext_enc_data,
	output logic [71:0] ext_enc_word,
	input wire logic [71:0] ext_dec_word,
	output logic [63:0] ext_dec_data,
	output logic ext_dec_sbit,
	output logic ext_dec_dbit,
	// Cascade path to the adjacent tiles.
	input wire logic [71:0] cas_in_data,
	input wire logic cas_in_valid,
	output logic [71:0] cas_out_data,
	output logic cas_out_valid
);

	// ==========================================================
	// Storage and state.
	logic [71:0] mem [dpr_pkg::MEM_WORDS];
	dpr_pkg::dpr_state_s q;
	dpr_pkg::dpr_state_s s;

	// Per-port working signals of the access stage.
	logic [1:0][15:0] ain;
	logic [1:0][2:0] wc;
	logic [1:0][6:0] wb;
	logic [1:0] wr;
	logic [1:0] rd;
	logic [1:0] eccw;
	logic [1:0][22:0] prod;
	logic [1:0][15:0] ba;
	logic [1:0][8:0] wi;
	logic [1:0][6:0] off;
	logic [1:0][71:0] msk;
	logic [1:0][71:0] item;
	logic [1:0][71:0] nw;
	logic [1:0][71:0] rword;
	logic [1:0][71:0] rdat;
	logic [1:0][65:0] dc;
	logic [71:0] base1;
	logic [15:0] cap;
	logic [2:0] maxw;
	logic fifo_m;
	logic split_m;
	logic rws_m;
	logic hit;

	assign ain[0] = a_addr;
	assign ain[1] = b_addr;
	assign fifo_m = q.ctrl[dpr_pkg::CTRL_FIFO];
	assign split_m = q.ctrl[dpr_pkg::CTRL_SPLIT];
	assign rws_m = q.ctrl[dpr_pkg::CTRL_RWS];

	// Next-state logic for the whole tile.
	always_comb begin
		s = q;
		// Capacity and widest legal width for the current shape.
		cap = split_m ? dpr_pkg::HALF_BITS : dpr_pkg::FULL_BITS;
		if (split_m) begin
			maxw = rws_m ? 3'(dpr_pkg::DPR_W36) : 3'(dpr_pkg::DPR_W18);
		end else begin
			maxw = rws_m ? 3'(dpr_pkg::DPR_W72) : 3'(dpr_pkg::DPR_W36);
		end
		wc[0] = q.ctrl[dpr_pkg::CTRL_WID_A +: 3];
		wc[1] = q.ctrl[dpr_pkg::CTRL_WID_B +: 3];
		for (int p = 0; p < 2; p++) begin
			if (wc[p] > maxw) begin
				wc[p] = maxw;
			end
		end
		// In split mode the wider side is pinned at the widest width.
		if (rws_m) begin
			if (wc[0] >= wc[1]) begin
				wc[0] = maxw;
			end else begin
				wc[1] = maxw;
			end
		end
		base1 = '0;
		for (int p = 0; p < 2; p++) begin
			wb[p] = dpr_pkg::width_bits(wc[p]);
			eccw[p] = q.ctrl[dpr_pkg::CTRL_ECC] && (wb[p] == 7'h48);
			// Input stage: enables and data captured each clock, address only when enabled.
			s.en[p] = (p == 0 ? a_ce : b_ce) & ~pwr_gate;
			s.we[p] = (p == 0 ? a_we : b_we);
			s.din[p] = (p == 0 ? a_din : b_din);
			if (s.en[p]) begin
				s.addr[p] = ain[p];
			end
			// Who may read and write in this cycle.
			if (fifo_m) begin
				wr[p] = (p == 0) && q.en[0] && !q.full;
				rd[p] = (p == 1) && q.en[1] && !q.empty;
			end else if (rws_m) begin
				wr[p] = (p == 0) && q.en[0] && q.we[0];
				rd[p] = (p == 1) && q.en[1];
			end else begin
				wr[p] = q.en[p] && q.we[p];
				rd[p] = q.en[p] && !q.we[p];
			end
			// Bit address in the linear array; every width divides 72.
			prod[p] = 23'(q.ctrl[dpr_pkg::CTRL_ADIS] ? ain[p] : q.addr[p]) * 23'(wb[p]);
			if (fifo_m) begin
				ba[p] = (p == 0) ? q.wptr : q.rptr;
			end else begin
				ba[p] = 16'(prod[p] % 23'(cap));
				if (split_m && (p == 1)) begin
					ba[p] = ba[p] + dpr_pkg::HALF_BITS;
				end
			end
			wi[p] = 9'(ba[p] / dpr_pkg::WORD_BITS);
			off[p] = 7'(ba[p] % dpr_pkg::WORD_BITS);
			rword[p] = mem[wi[p]];
			msk[p] = dpr_pkg::width_mask(wb[p]) << off[p];
			item[p] = eccw[p] ? dpr_pkg::ecc_encode(q.din[p][63:0]) : q.din[p];
			// A same-word write from port A is merged so neither is lost.
			base1 = (p == 1 && wr[0] && (wi[1] == wi[0])) ? nw[0] : rword[p];
			nw[p] = (base1 & ~msk[p]) | ((item[p] << off[p]) & msk[p]);
			// Read side: slice out the item and correct it if protected.
			dc[p] = dpr_pkg::ecc_decode(rword[p]);
			if (eccw[p]) begin
				rdat[p] = {rword[p][71:64], dc[p][63:0]};
			end else begin
				rdat[p] = (rword[p] >> off[p]) & dpr_pkg::width_mask(wb[p]);
			end
			// First output stage with the write-cycle behaviour.
			if (wr[p]) begin
				unique case (q.ctrl[(p == 0 ? dpr_pkg::CTRL_WM_A : dpr_pkg::CTRL_WM_B) +: 2])
					dpr_pkg::DPR_READ_FIRST: begin
						s.dout1[p] = rdat[p];
						s.sb1[p] = eccw[p] & dc[p][64];
						s.db1[p] = eccw[p] & dc[p][65];
					end
					dpr_pkg::DPR_WRITE_FIRST: begin
						s.dout1[p] = q.din[p] & dpr_pkg::width_mask(wb[p]);
						s.sb1[p] = 1'b0;
						s.db1[p] = 1'b0;
					end
					default: begin
						s.dout1[p] = q.dout1[p];
					end
				endcase
			end else if (rd[p]) begin
				s.dout1[p] = rdat[p];
				s.sb1[p] = eccw[p] & dc[p][64];
				s.db1[p] = eccw[p] & dc[p][65];
				if (eccw[p] && dc[p][64] && (s.sgl_cnt != 16'hFFFF)) begin
					s.sgl_cnt = s.sgl_cnt + 16'h0001;
				end
				if (eccw[p] && dc[p][65] && (s.dbl_cnt != 16'hFFFF)) begin
					s.dbl_cnt = s.dbl_cnt + 16'h0001;
				end
			end
		end
		// Optional pipeline register on the read data.
		s.dout2 = q.dout1;
		s.sb2 = q.sb1;
		s.db2 = q.db1;
		s.rv1 = rd[1];
		s.rv2 = q.rv1;
		// FIFO pointers and fill level, counted in bits.
		if (wr[0] && fifo_m) begin
			s.wptr = ((q.wptr + 16'(wb[0])) >= cap) ? 16'h0000 : q.wptr + 16'(wb[0]);
			s.cnt = s.cnt + 17'(wb[0]);
		end
		if (rd[1] && fifo_m) begin
			s.rptr = ((q.rptr + 16'(wb[1])) >= cap) ? 16'h0000 : q.rptr + 16'(wb[1]);
			s.cnt = s.cnt - 17'(wb[1]);
		end
		if (q.ctrl[dpr_pkg::CTRL_FLUSH]) begin
			s.wptr = '0;
			s.rptr = '0;
			s.cnt = '0;
			s.ctrl[dpr_pkg::CTRL_FLUSH] = 1'b0;
		end
		s.full = (s.cnt + 17'(wb[0])) > 17'(cap);
		s.empty = s.cnt < 17'(wb[1]);
		s.afull = s.cnt >= 17'(q.afull_th);
		s.aempty = s.cnt <= 17'(q.aempty_th);
		// Stand-alone coder, registered.
		s.enc = dpr_pkg::ecc_encode(ext_enc_data);
		s.dec = dpr_pkg::ecc_decode(ext_dec_word);
		// Register decode; read data is captured in the setup phase.
		hit = 1'b1;
		unique case (paddr)
			dpr_pkg::OFS_CTRL: s.prdata = q.ctrl;
			dpr_pkg::OFS_AFULL: s.prdata = {16'h0000, q.afull_th};
			dpr_pkg::OFS_AEMPTY: s.prdata = {16'h0000, q.aempty_th};
			dpr_pkg::OFS_STATUS: s.prdata = {q.cnt[15:0], 12'h000, q.aempty, q.afull, q.empty, q.full};
			dpr_pkg::OFS_ECCCNT: s.prdata = {q.dbl_cnt, q.sgl_cnt};
			default: begin
				s.prdata = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
		if (!(psel && !penable)) begin
			s.prdata = q.prdata;
		end
		if (psel && penable && pwrite) begin
			for (int i = 0; i < 4; i++) begin
				if (pstrb[i]) begin
					unique case (paddr)
						dpr_pkg::OFS_CTRL: s.ctrl[8 * i +: 8] = pwdata[8 * i +: 8];
						dpr_pkg::OFS_AFULL: begin
							if (i < 2) begin
								s.afull_th[8 * (i % 2) +: 8] = pwdata[8 * i +: 8];
							end
						end
						dpr_pkg::OFS_AEMPTY: begin
							if (i < 2) begin
								s.aempty_th[8 * (i % 2) +: 8] = pwdata[8 * i +: 8];
							end
						end
						default: begin
						end
					endcase
				end
			end
			// Writing the error counter register clears both counts.
			if (paddr == dpr_pkg::OFS_ECCCNT) begin
				s.sgl_cnt = '0;
				s.dbl_cnt = '0;
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl <= dpr_pkg::RST_CTRL;
			q.afull_th <= dpr_pkg::RST_AFULL;
			q.aempty_th <= dpr_pkg::RST_AEMPTY;
			q.empty <= 1'b1;
			q.aempty <= 1'b1;
		end else begin
			q <= s;
		end
	end

	// Array writes; port B is applied on top of port A in a shared word.
	always_ff @(posedge pclk) begin
		if (wr[0]) begin
			mem[wi[0]] <= nw[0];
		end
		if (wr[1]) begin
			mem[wi[1]] <= nw[1];
		end
	end

	// Outputs.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = q.prdata;
	assign a_dout = q.ctrl[dpr_pkg::CTRL_OREG_A] ? q.dout2[0] : q.dout1[0];
	assign a_sbit_err = q.ctrl[dpr_pkg::CTRL_OREG_A] ? q.sb2[0] : q.sb1[0];
	assign a_dbit_err = q.ctrl[dpr_pkg::CTRL_OREG_A] ? q.db2[0] : q.db1[0];
	assign cas_out_data = q.ctrl[dpr_pkg::CTRL_OREG_B] ? q.dout2[1] : q.dout1[1];
	assign cas_out_valid = q.ctrl[dpr_pkg::CTRL_OREG_B] ? q.rv2 : q.rv1;
	assign b_dout = (q.ctrl[dpr_pkg::CTRL_CASC] && cas_in_valid) ? cas_in_data : cas_out_data;
	assign b_sbit_err = q.ctrl[dpr_pkg::CTRL_OREG_B] ? q.sb2[1] : q.sb1[1];
	assign b_dbit_err = q.ctrl[dpr_pkg::CTRL_OREG_B] ? q.db2[1] : q.db1[1];
	assign fifo_full = q.full;
	assign fifo_empty = q.empty;
	assign fifo_afull = q.afull;
	assign fifo_aempty = q.aempty;
	assign ext_enc_word = q.enc;
	assign ext_dec_data = q.dec[63:0];
	assign ext_dec_sbit = q.dec[64];
	assign ext_dec_dbit = q.dec[65];

endmodule

// [test/dpr_tile_properties.sv]
// Port assertions for the dual-port memory tile.
// Assumes a single pclk domain; bound into every tile instance.
`timescale 1ns/1ps
module dpr_tile_properties (
	// Clock, reset and register bus.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Port enables, error flags and FIFO flags.
	input wire logic a_ce,
	input wire logic b_ce,
	input wire logic a_sbit_err,
	input wire logic a_dbit_err,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	// Stand-alone coder.
	input wire logic [63:0] ext_enc_data,
	input wire logic [71:0] ext_enc_word,
	input wire logic [71:0] ext_dec_word,
	input wire logic [63:0] ext_dec_data,
	input wire logic ext_dec_sbit,
	input wire logic ext_dec_dbit
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic apb_wr, push_c, pop_c, mapped;
	logic [63:0] dec_lo;
	// ==========================================================
	// Causes that may move a flag; a register write may too.
	assign apb_wr = psel && penable && pwrite;
	assign push_c = a_ce || apb_wr;
	assign pop_c = b_ce || apb_wr;
	assign mapped = (paddr <= 12'h010) && (paddr[1:0] == 2'h0);
	assign dec_lo = ext_dec_word[63:0];
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// ==========================================================
	// Bus, coder and flag relations.
	a_apb_ready: assert property (s_setup ##1 s_access |-> pready)
		else $error("access phase not answered");
	a_slverr_map: assert property (pslverr == (psel && penable && !mapped))
		else $error("slave error does not match the address map");
	a_unmapped_zero: assert property (s_setup ##1 (s_access and (!pwrite && !mapped)) |->
		prdata == 32'h0)
		else $error("unmapped read not zero");
	a_enc_data: assert property (ext_enc_word[63:0] == $past(ext_enc_data))
		else $error("coded word does not carry its data");
	a_dec_clean: assert property (!ext_dec_sbit && !ext_dec_dbit |-> ext_dec_data == $past(dec_lo))
		else $error("clean word altered by the decoder");
	a_err_excl: assert property (!(a_sbit_err && a_dbit_err) && !(ext_dec_sbit && ext_dec_dbit))
		else $error("single and double error flagged together");
	a_flag_excl: assert property (!(fifo_full && fifo_empty))
		else $error("full and empty together");
	a_fill_cause: assert property (($rose(fifo_full) || $fell(fifo_empty)) |->
		$past(push_c) || $past(push_c, 2) || $past(push_c, 3) || $past(push_c, 4))
		else $error("fill flag moved without a push");
	a_drain_cause: assert property (($fell(fifo_full) || $rose(fifo_empty)) |->
		$past(pop_c) || $past(pop_c, 2) || $past(pop_c, 3) || $past(pop_c, 4))
		else $error("drain flag moved without a pop");
endmodule
bind dpr_tile dpr_tile_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .a_ce(a_ce), .b_ce(b_ce), .a_sbit_err(a_sbit_err),
	.a_dbit_err(a_dbit_err), .fifo_full(fifo_full), .fifo_empty(fifo_empty),
	.ext_enc_data(ext_enc_data), .ext_enc_word(ext_enc_word), .ext_dec_word(ext_dec_word),
	.ext_dec_data(ext_dec_data), .ext_dec_sbit(ext_dec_sbit), .ext_dec_dbit(ext_dec_dbit));

// [test/dpr_fabric.sv]
// Fabric logic model driving both data ports of the tile.
// Assumes the tile captures its port inputs on the rising edge of pclk.
`timescale 1ns/1ps
module dpr_fabric (
	// Clock.
	input wire logic pclk,
	// Port A.
	output logic a_ce,
	output logic a_we,
	output logic [15:0] a_addr,
	output logic [71:0] a_din,
	input wire logic [71:0] a_dout,
	// Port B.
	output logic b_ce,
	output logic b_we,
	output logic [15:0] b_addr,
	output logic [71:0] b_din,
	input wire logic [71:0] b_dout
);
	// ==========================================================
	// Idle lines at time zero.
	initial begin
		a_ce = 1'b0;
		a_we = 1'b0;
		a_addr = 16'h0;
		a_din = 72'h0;
		b_ce = 1'b0;
		b_we = 1'b0;
		b_addr = 16'h0;
		b_din = 72'h0;
	end
	// Drives one port's request lines.
	task automatic put(input bit p, input logic ce, input logic we, input logic [15:0] ad,
		input logic [71:0] d);
		if (p) begin
			b_ce <= ce;
			b_we <= we;
			b_addr <= ad;
			b_din <= d;
		end else begin
			a_ce <= ce;
			a_we <= we;
			a_addr <= ad;
			a_din <= d;
		end
	endtask
	// One access; early is the output one edge before the answer.
	task automatic op(input bit p, input logic we, input logic [15:0] ad,
		input logic [71:0] d, input int lat, output logic [71:0] early, output logic [71:0] q);
		@(posedge pclk);
		put(p, 1'b1, we, ad, d);
		@(posedge pclk);
		// Released lines show the inverse so a stale value never passes.
		put(p, 1'b0, 1'b0, ~ad, ~d);
		repeat (lat - 1) @(posedge pclk);
		#1 early = p ? b_dout : a_dout;
		@(posedge pclk);
		#1 q = p ? b_dout : a_dout;
	endtask
endmodule

// [test/dpr_tile_tb_top.sv]
// Self-checking bench for the dual-port memory tile.
// Assumes the package, tile, checker and fabric model are compiled first.
`timescale 1ns/1ps
module dpr_tile_tb_top;
	localparam logic [63:0] K = 64'h0123_4567_89AB_CDEF;
	localparam int LIMIT = 20000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pwr_gate;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic a_ce, a_we, a_sbit_err, a_dbit_err, b_ce, b_we, b_sbit_err, b_dbit_err;
	logic [15:0] a_addr, b_addr;
	logic [71:0] a_din, a_dout, b_din, b_dout, e, q, x, m, ext_enc_word, ext_dec_word;
	logic [71:0] cas_in_data, cas_out_data;
	logic [63:0] ext_enc_data, ext_dec_data;
	logic fifo_full, fifo_empty, fifo_afull, fifo_aempty, ext_dec_sbit, ext_dec_dbit;
	logic cas_in_valid, cas_out_valid;
	int n_mismatch, n_compared, cyc, s;
	int wd[6] = '{1, 2, 4, 9, 18, 36};
	// ==========================================================
	// Design, fabric model and clock.
	dpr_tile uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .a_ce(a_ce), .a_we(a_we), .a_addr(a_addr),
		.a_din(a_din), .a_dout(a_dout), .a_sbit_err(a_sbit_err), .a_dbit_err(a_dbit_err),
		.b_ce(b_ce), .b_we(b_we), .b_addr(b_addr), .b_din(b_din), .b_dout(b_dout),
		.b_sbit_err(b_sbit_err), .b_dbit_err(b_dbit_err), .fifo_full(fifo_full),
		.fifo_empty(fifo_empty), .fifo_afull(fifo_afull), .fifo_aempty(fifo_aempty),
		.pwr_gate(pwr_gate), .ext_enc_data(ext_enc_data), .ext_enc_word(ext_enc_word),
		.ext_dec_word(ext_dec_word), .ext_dec_data(ext_dec_data), .ext_dec_sbit(ext_dec_sbit),
		.ext_dec_dbit(ext_dec_dbit), .cas_in_data(cas_in_data), .cas_in_valid(cas_in_valid),
		.cas_out_data(cas_out_data), .cas_out_valid(cas_out_valid));
	dpr_fabric fab (.pclk(pclk), .a_ce(a_ce), .a_we(a_we), .a_addr(a_addr), .a_din(a_din),
		.a_dout(a_dout), .b_ce(b_ce), .b_we(b_we), .b_addr(b_addr), .b_din(b_din),
		.b_dout(b_dout));
	// Free-running 200 MHz clock.
	always #2.5 pclk = ~pclk;
	// Cuts a hung run short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ==========================================================
	// Comparisons, bus cycles and the closing report.
	task automatic chk(input string what, input logic [71:0] ex, input logic [71:0] got);
		n_compared++;
		if (got !== ex) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, ex, got);
		end
	endtask
	task automatic chk_r(input string what, input logic [31:0] ex, input logic [31:0] got);
		chk(what, {40'h0, ex}, {40'h0, got});
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd_v);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd_v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] ad, input logic [31:0] ex);
		apb(1'b0, ad, 32'h0);
		chk_r("register", ex, r);
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, pwr_gate, cas_in_valid} = 5'h0;
		{paddr, pwdata, ext_enc_data, ext_dec_word, cas_in_data} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1 chk_r("flags", 32'hA, {28'h0, fifo_aempty, fifo_afull, fifo_empty, fifo_full});
		rdc(dpr_pkg::OFS_CTRL, dpr_pkg::RST_CTRL);
		rdc(dpr_pkg::OFS_AFULL, 32'h8000);
		rdc(dpr_pkg::OFS_AEMPTY, 32'h0100);
		rdc(12'h020, 32'h0);
		chk_r("pslverr", 32'h1, {31'h0, err});
		// Stand-alone coder with none, one and two flipped bits.
		@(posedge pclk) ext_enc_data <= K;
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			ext_dec_word <= ext_enc_word ^ (72'h3 >> (2 - i));
			repeat (2) @(posedge pclk);
			#1 chk_r("dec_err", {30'h0, i == 1, i == 2}, {30'h0, ext_dec_sbit, ext_dec_dbit});
			if (i < 2) chk("dec", {8'h0, K}, {8'h0, ext_dec_data});
			@(posedge pclk);
		end
		// Every read shape up to 36 bits against one 36-bit item.
		x = 72'h9_8765_4321;
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0000_5000);
		fab.op(1'b0, 1'b1, 16'h0, x, 1, e, q);
		for (int c = 0; c < 6; c++) begin
			apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0000_5000 | (c << 16));
			s = (c == 3) ? 27 : 0;
			fab.op(1'b1, 1'b0, 16'(s / 9), 72'h0, 1, e, q);
			m = (72'h1 << wd[c]) - 72'h1;
			chk("b_dout", (x >> s) & m, q & m);
		end
		// Output seen during a write in each mode.
		for (int md = 0; md < 3; md++) begin
			apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0005_5000 | (md << 8));
			fab.op(1'b0, 1'b1, 16'h6, 72'h66, 1, e, q);
			fab.op(1'b0, 1'b1, 16'h5, 72'(16 + md), 1, e, q);
			fab.op(1'b0, 1'b0, 16'h6, 72'h0, 1, e, q);
			fab.op(1'b0, 1'b1, 16'h5, 72'(32 + md), 1, e, q);
			x = (md == 0) ? 72'(16 + md) : (md == 1) ? 72'(32 + md) : 72'h66;
			chk("a_dout", x, q & 72'hF_FFFF_FFFF);
		end
		// Output register delays the answer by one edge.
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0005_5008);
		fab.op(1'b0, 1'b0, 16'h6, 72'h0, 2, e, q);
		fab.op(1'b0, 1'b0, 16'h5, 72'h0, 2, e, q);
		chk("a_dout early", 72'h66, e & 72'hF_FFFF_FFFF);
		chk("a_dout", 72'h22, q & 72'hF_FFFF_FFFF);
		// A write under power gating is dropped.
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0005_5000);
		@(posedge pclk) pwr_gate <= 1'b1;
		fab.op(1'b0, 1'b1, 16'h5, 72'h55, 1, e, q);
		@(posedge pclk) pwr_gate <= 1'b0;
		fab.op(1'b0, 1'b0, 16'h5, 72'h0, 1, e, q);
		chk("a_dout", 72'h22, q & 72'hF_FFFF_FFFF);
		// Two 18Kb halves keep separate contents.
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0004_4002);
		fab.op(1'b0, 1'b1, 16'h0, 72'h1_2345, 1, e, q);
		fab.op(1'b1, 1'b1, 16'h0, 72'h2_ABCD, 1, e, q);
		fab.op(1'b0, 1'b0, 16'h0, 72'h0, 1, e, q);
		chk("a_dout", 72'h1_2345, q & 72'h3_FFFF);
		fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1, e, q);
		chk("b_dout", 72'h2_ABCD, q & 72'h3_FFFF);
		chk("cas_out_data", 72'h2_ABCD, cas_out_data & 72'h3_FFFF);
		chk_r("cas_out_valid", 32'h1, {31'h0, cas_out_valid});
		// Coded words in the array; port B writes are ignored here.
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0006_6044);
		fab.op(1'b0, 1'b1, 16'h0, {8'h0, K}, 1, e, q);
		fab.op(1'b1, 1'b1, 16'h0, 72'h0, 1, e, q);
		fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1, e, q);
		chk("b_dout", {8'h0, K}, {8'h0, q[63:0]});
		chk_r("b_err", 32'h0, {30'h0, b_sbit_err, b_dbit_err});
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0006_6004);
		fab.op(1'b0, 1'b1, 16'h1, ext_enc_word ^ 72'h10, 1, e, q);
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0006_6044);
		fab.op(1'b1, 1'b0, 16'h1, 72'h0, 1, e, q);
		chk("b_dout", {8'h0, K}, {8'h0, q[63:0]});
		chk_r("b_err", 32'h2, {30'h0, b_sbit_err, b_dbit_err});
		fab.op(1'b0, 1'b1, 16'h1, 72'h0, 1, e, q);
		chk("a_dout", {8'h0, K}, {8'h0, q[63:0]});
		chk_r("a_err", 32'h2, {30'h0, a_sbit_err, a_dbit_err});
		// Cascade input shown on port B.
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0000_0080);
		@(posedge pclk) cas_in_valid <= 1'b1;
		cas_in_data <= {8'h0, K};
		#1 chk("b_dout", {8'h0, K}, b_dout);
		@(posedge pclk) cas_in_valid <= 1'b0;
		cas_in_data <= ~{8'h0, K};
		// FIFO: narrow reads, thresholds, fill to full and drain.
		x = 72'h9_8765_4321;
		apb(1'b1, dpr_pkg::OFS_AFULL, 32'h48);
		apb(1'b1, dpr_pkg::OFS_AEMPTY, 32'h24);
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0003_5001);
		fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1, e, q);
		fab.op(1'b0, 1'b1, 16'h0, x, 1, e, q);
		rdc(dpr_pkg::OFS_STATUS, 32'h0024_0008);
		for (int i = 0; i < 4; i++) begin
			fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1, e, q);
			chk("b_dout", (x >> (9 * i)) & 72'h1FF, q & 72'h1FF);
		end
		rdc(dpr_pkg::OFS_STATUS, 32'h0000_000A);
		apb(1'b1, dpr_pkg::OFS_CTRL, 32'h0005_5001);
		for (int i = 0; i < 1024; i++) begin
			fab.op(1'b0, 1'b1, 16'h0, 72'(i), 1, e, q);
		end
		fab.op(1'b0, 1'b1, 16'h0, 72'hBAD, 1, e, q);
		rdc(dpr_pkg::OFS_STATUS, 32'h9000_0005);
		chk_r("flags", 32'h5, {28'h0, fifo_aempty, fifo_afull, fifo_empty, fifo_full});
		for (int i = 0; i < 1024; i++) begin
			fab.op(1'b1, 1'b0, 16'h0, 72'h0, 1, e, q);
			chk("b_dout", 72'(i), q & 72'hF_FFFF_FFFF);
		end
		rdc(dpr_pkg::OFS_STATUS, 32'h0000_000A);
		end_of_test();
	end
endmodule
